// ---- core/ars_autoreclose.sv ----
// Autoreclose shot sequencer: shot timing, breaker commands, counters, register port.
// Assumes inputs synchronous to REF_CLK_I and a breaker with open/closed feedback.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module ars_autoreclose
  import ars_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WR_DATA_I,
  input wire logic WR_STB_I,
  input wire logic RD_STB_I,
  output logic [31:0] RD_DATA_O,
  input wire logic OVERCURRENT_I,
  input wire logic RECLOSE_REQUEST_ONE_I,
  input wire logic RECLOSE_REQUEST_TWO_I,
  input wire logic BRK_OPEN_I,
  input wire logic BRK_CLOSED_I,
  input wire logic CLOSE_BLOCK_INPUT_I,
  output logic OPEN_BREAKER_OUTPUT_O,
  output logic CLOSE_BREAKER_OUTPUT_O,
  output logic [1:0] FINAL_TRIP_EVENT_O,
  output logic [3:0] FUNC_STATE_O,
  output logic [3:0] BREAKER_OBJECT_STATE_O,
  output logic [2:0] SHOT_O,
  output logic [1:0] ACTIVE_TIMER_KIND_O
);

  ars_state_s q;
  ars_state_s d;
  ars_bus_s bus;
  logic tick;
  logic expired;
  logic [2:0] si;
  logic req_any;

  assign bus = '{addr: ADDR_I, wdata: WR_DATA_I, wr: WR_STB_I, rd: RD_STB_I};
  assign tick = (q.prediv == 20'(TICK_CYCLES - 1));
  assign expired = (q.tmr == 16'h0000);
  assign si = q.shot - 3'h1;
  assign req_any = RECLOSE_REQUEST_ONE_I | RECLOSE_REQUEST_TWO_I;

  always_comb begin
    d = q;
    d.rdata = 32'h0000_0000;
    // Common time base and running timer
    d.prediv = tick ? 20'h0_0000 : q.prediv + 20'h0_0001;
    if (tick && !expired) begin
      d.tmr = q.tmr - 16'h0001;
    end
    case (q.fsm)
      S_INIT: begin
        d.fsm = q.en ? S_READY : S_INHIBIT;
      end
      S_READY: begin
        d.shot = 3'h1;
        if (!q.en) begin
          d.fsm = S_INHIBIT;
        end else if (req_any && OVERCURRENT_I) begin
          d.src = !RECLOSE_REQUEST_ONE_I;
          d.total = q.total + 16'h0001;
          d.pcnt[!RECLOSE_REQUEST_ONE_I][0] = q.pcnt[!RECLOSE_REQUEST_ONE_I][0] + 16'h0001;
          d.tmr = q.start[0];
          d.prediv = 20'h0_0000;
          d.kind = TK_START;
          d.fsm = S_START;
        end
      end
      S_START: begin
        if (!OVERCURRENT_I) begin
          d.fsm = S_READY;
        end else if (expired) begin
          d.open_cmd = 1'b1;
          d.tmr = q.brk_to;
          d.prediv = 20'h0_0000;
          d.fsm = S_OPENING;
        end
      end
      S_OPENING: begin
        if (BRK_OPEN_I) begin
          d.open_cmd = 1'b0;
          d.tmr = q.dead[si];
          d.prediv = 20'h0_0000;
          d.kind = TK_DEAD;
          d.fsm = S_DEAD;
        end else if (expired) begin
          d.open_cmd = 1'b0;
          d.fsm = S_BRK_FAIL;
        end
      end
      S_DEAD: begin
        if (expired && !CLOSE_BLOCK_INPUT_I) begin
          d.close_cmd = 1'b1;
          d.tmr = q.brk_to;
          d.prediv = 20'h0_0000;
          d.fsm = S_CLOSING;
        end
      end
      S_CLOSING: begin
        if (BRK_CLOSED_I) begin
          d.close_cmd = 1'b0;
          d.tmr = q.discr[si];
          d.prediv = 20'h0_0000;
          d.kind = TK_DISCR;
          d.fsm = S_DISCR;
        end else if (expired) begin
          d.close_cmd = 1'b0;
          d.fsm = S_BRK_FAIL;
        end
      end
      S_DISCR: begin
        if (expired) begin
          if (OVERCURRENT_I) begin
            d.open_cmd = 1'b1;
            d.fail = q.fail + 16'h0001;
            d.tmr = q.brk_to;
            d.prediv = 20'h0_0000;
            if (q.shot < q.shots) begin
              d.shot = q.shot + 3'h1;
              d.pcnt[q.src][q.shot] = q.pcnt[q.src][q.shot] + 16'h0001;
              d.fsm = S_OPENING;
            end else begin
              d.ftrip[q.src] = 1'b1;
              d.tmr = FTRIP_HOLD;
              d.fsm = S_FTRIP;
            end
          end else begin
            d.tmr = q.reclaim;
            d.prediv = 20'h0_0000;
            d.kind = TK_RECLAIM;
            d.fsm = S_RECLAIM;
          end
        end
      end
      S_RECLAIM: begin
        if (expired) begin
          d.shot = 3'h1;
          d.fsm = S_READY;
        end
      end
      S_FTRIP: begin
        if (BRK_OPEN_I) begin
          d.open_cmd = 1'b0;
        end
        if (expired) begin
          d.ftrip = 2'b00;
          d.open_cmd = 1'b0;
          d.fsm = S_LOCKED;
        end
      end
      S_LOCKED: begin
        if (!req_any && !OVERCURRENT_I) begin
          d.fsm = S_READY;
        end
      end
      S_BRK_FAIL: begin
        if (!q.en) begin
          d.fsm = S_INHIBIT;
        end
      end
      S_INHIBIT: begin
        if (q.en) begin
          d.fsm = S_READY;
        end
      end
      default: begin
        d.fsm = S_INIT;
      end
    endcase
    // Register writes
    if (bus.wr) begin
      if (bus.addr == A_CTRL) begin
        d.en = bus.wdata[0];
        if (bus.wdata[3:1] >= 3'h1 && bus.wdata[3:1] <= 3'(NUM_SHOTS)) begin
          d.shots = bus.wdata[3:1];
        end
      end
      if (bus.addr == A_RECLAIM) begin
        d.reclaim = bus.wdata[15:0];
      end
      if (bus.addr == A_BRK_TO) begin
        d.brk_to = bus.wdata[15:0];
      end
      for (int i = 0; i < NUM_SHOTS; i++) begin
        if (bus.addr == A_DEAD + 8'(4 * i)) begin
          d.dead[i] = bus.wdata[15:0];
        end
        if (bus.addr == A_START + 8'(4 * i)) begin
          d.start[i] = bus.wdata[15:0];
        end
        if (bus.addr == A_DISCR + 8'(4 * i)) begin
          d.discr[i] = bus.wdata[15:0];
        end
      end
    end
    // Reported function state
    case (d.fsm)
      S_INIT: d.func = FS_INIT;
      S_RECLAIM: d.func = FS_RECLAIM;
      S_READY: d.func = FS_READY;
      S_START: d.func = FS_WAIT_OPEN;
      S_OPENING: d.func = FS_WAIT_OPEN;
      S_DEAD: d.func = FS_WAIT_CLOSE;
      S_CLOSING: d.func = FS_WAIT_CLOSE;
      S_DISCR: d.func = FS_DISCR;
      S_LOCKED: d.func = FS_LOCKED;
      S_FTRIP: d.func = FS_FINAL_TRIP;
      S_BRK_FAIL: d.func = FS_BRK_FAIL;
      S_INHIBIT: d.func = FS_INHIBIT;
      default: d.func = FS_INIT;
    endcase
    // Breaker object state
    if (d.fsm == S_BRK_FAIL) begin
      d.obj = OB_FAIL;
    end else if (d.open_cmd) begin
      d.obj = OB_OPEN_REQ;
    end else if (d.close_cmd) begin
      d.obj = OB_CLOSE_REQ;
    end else if (BRK_OPEN_I && !BRK_CLOSED_I) begin
      d.obj = OB_OPEN;
    end else if (BRK_CLOSED_I && !BRK_OPEN_I) begin
      d.obj = OB_CLOSE;
    end else begin
      d.obj = OB_UNDEFINED;
    end
    // Register reads, data valid the cycle after the strobe
    if (bus.rd) begin
      case (bus.addr)
        A_CTRL: d.rdata = {28'h000_0000, q.shots, q.en};
        A_RECLAIM: d.rdata = {16'h0000, q.reclaim};
        A_BRK_TO: d.rdata = {16'h0000, q.brk_to};
        A_STATUS: d.rdata = {18'h0_0000, q.kind, 1'b0, q.shot, q.obj, q.func};
        A_TOTAL: d.rdata = {16'h0000, q.total};
        A_FAIL: d.rdata = {16'h0000, q.fail};
        default: d.rdata = 32'h0000_0000;
      endcase
      for (int i = 0; i < NUM_SHOTS; i++) begin
        if (bus.addr == A_DEAD + 8'(4 * i)) d.rdata = {16'h0000, q.dead[i]};
        if (bus.addr == A_START + 8'(4 * i)) d.rdata = {16'h0000, q.start[i]};
        if (bus.addr == A_DISCR + 8'(4 * i)) d.rdata = {16'h0000, q.discr[i]};
        if (bus.addr == A_CNT_ONE + 8'(4 * i)) d.rdata = {16'h0000, q.pcnt[0][i]};
        if (bus.addr == A_CNT_TWO + 8'(4 * i)) d.rdata = {16'h0000, q.pcnt[1][i]};
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.fsm <= S_INIT;
      q.en <= 1'b1;
      q.shots <= SHOTS_RST;
      q.reclaim <= RECLAIM_RST;
      q.brk_to <= BRK_TO_RST;
      q.dead <= {NUM_SHOTS{DEAD_RST}};
      q.start <= {NUM_SHOTS{START_RST}};
      q.discr <= {NUM_SHOTS{DISCR_RST}};
      q.shot <= 3'h1;
      q.kind <= TK_RECLAIM;
      q.obj <= OB_UNDEFINED;
      q.func <= FS_INIT;
    end else begin
      q <= d;
    end
  end

  assign RD_DATA_O = q.rdata;
  assign OPEN_BREAKER_OUTPUT_O = q.open_cmd;
  assign CLOSE_BREAKER_OUTPUT_O = q.close_cmd;
  assign FINAL_TRIP_EVENT_O = q.ftrip;
  assign FUNC_STATE_O = q.func;
  assign BREAKER_OBJECT_STATE_O = q.obj;
  assign SHOT_O = q.shot;
  assign ACTIVE_TIMER_KIND_O = q.kind;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  chk_start_loads_delay: assert property (q.fsm == S_READY && q.en && req_any
    && OVERCURRENT_I |=> q.fsm == S_START && q.kind == TK_START && q.shot == 3'h1)
    else $error("start delay not begun");
  chk_open_after_start: assert property (q.fsm == S_START && expired
    && OVERCURRENT_I |=> q.open_cmd && q.fsm == S_OPENING)
    else $error("open not commanded after start delay");
  chk_open_release: assert property (q.fsm == S_OPENING && BRK_OPEN_I
    |=> !q.open_cmd && q.fsm == S_DEAD && q.tmr == q.dead[si])
    else $error("open not released on breaker open");
  chk_close_on_dead: assert property (q.fsm == S_DEAD && expired
    && !CLOSE_BLOCK_INPUT_I |=> q.close_cmd)
    else $error("close not commanded after dead time");
  chk_close_release: assert property (q.fsm == S_CLOSING && BRK_CLOSED_I
    |=> !q.close_cmd && q.kind == TK_DISCR)
    else $error("close not released on breaker closed");
  chk_reopen_discr: assert property (q.fsm == S_DISCR && expired && OVERCURRENT_I
    |=> q.open_cmd && q.fail == $past(q.fail) + 16'h0001)
    else $error("no reopen after discrimination");
  chk_shot_advance: assert property (q.fsm == S_DISCR && expired && OVERCURRENT_I
    && q.shot < q.shots |=> q.shot == $past(q.shot) + 3'h1)
    else $error("shot did not advance");
  chk_reclaim_done: assert property (q.fsm == S_RECLAIM && expired
    |=> q.fsm == S_READY ##1 q.shot == 3'h1)
    else $error("reclaim did not end in ready");
  chk_shot_range: assert property (q.shot >= 3'h1 && q.shot <= 3'h5)
    else $error("shot out of range");
  chk_block_hold: assert property (q.fsm == S_DEAD && CLOSE_BLOCK_INPUT_I
    |=> !q.close_cmd)
    else $error("close issued while blocked");
  chk_ftrip_state: assert property ($rose(|q.ftrip) |-> q.fsm == S_FTRIP
    && q.tmr == FTRIP_HOLD)
    else $error("final trip flag without final trip");

  cov_reclaim: cover property (q.fsm == S_DISCR ##1 q.fsm == S_RECLAIM);
  cov_two_shots: cover property (q.shot == 3'h2 && q.fsm == S_DEAD);
  cov_final_trip: cover property ($rose(|q.ftrip));
  cov_brk_fail: cover property (q.fsm == S_BRK_FAIL);

endmodule

// ---- core/ars_pkg.sv ----
// Constants, encodings and state carrier for the autoreclose shot sequencer.
// Assumes one 50 MHz clock; all times are counted in 20 ms ticks.
package ars_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_MS = 20;
  localparam int TICK_CYC = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int NUM_SHOTS = 5;

  // Times in ticks of 20 ms
  localparam logic [15:0] DEAD_RST = 16'h00fa;
  localparam logic [15:0] RECLAIM_RST = 16'h01f4;
  localparam logic [15:0] START_RST = 16'h0001;
  localparam logic [15:0] DISCR_RST = 16'h0001;
  localparam logic [15:0] BRK_TO_RST = 16'h0032;
  localparam logic [15:0] FTRIP_HOLD = 16'h0019;
  localparam logic [2:0] SHOTS_RST = 3'h5;

  // Register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RECLAIM = 8'h04;
  localparam logic [7:0] A_BRK_TO = 8'h08;
  localparam logic [7:0] A_DEAD = 8'h10;
  localparam logic [7:0] A_START = 8'h30;
  localparam logic [7:0] A_DISCR = 8'h50;
  localparam logic [7:0] A_STATUS = 8'h80;
  localparam logic [7:0] A_TOTAL = 8'h84;
  localparam logic [7:0] A_FAIL = 8'h88;
  localparam logic [7:0] A_CNT_ONE = 8'ha0;
  localparam logic [7:0] A_CNT_TWO = 8'hc0;

  // Reported function state
  typedef enum logic [3:0] {
    FS_INIT, FS_RECLAIM, FS_READY, FS_WAIT_OPEN, FS_WAIT_CLOSE,
    FS_DISCR, FS_LOCKED, FS_FINAL_TRIP, FS_BRK_FAIL, FS_INHIBIT
  } ars_func_e;

  // Breaker object state
  typedef enum logic [3:0] {
    OB_UNDEFINED, OB_OPEN, OB_CLOSE, OB_OPEN_REQ, OB_CLOSE_REQ,
    OB_READY, OB_NOT_READY, OB_INFO_NA, OB_FAIL
  } ars_obj_e;

  typedef enum logic [1:0] {TK_RECLAIM, TK_START, TK_DEAD, TK_DISCR} ars_tkind_e;

  typedef enum logic [3:0] {
    S_INIT, S_RECLAIM, S_READY, S_START, S_OPENING, S_DEAD, S_CLOSING,
    S_DISCR, S_LOCKED, S_FTRIP, S_BRK_FAIL, S_INHIBIT
  } ars_st_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ars_bus_s;

  typedef struct packed {
    ars_st_e fsm;
    logic en;
    logic [2:0] shots;
    logic [15:0] reclaim;
    logic [15:0] brk_to;
    logic [4:0][15:0] dead;
    logic [4:0][15:0] start;
    logic [4:0][15:0] discr;
    logic [19:0] prediv;
    logic [15:0] tmr;
    logic [2:0] shot;
    logic src;
    ars_tkind_e kind;
    logic open_cmd;
    logic close_cmd;
    logic [1:0] ftrip;
    logic [15:0] total;
    logic [15:0] fail;
    logic [1:0][4:0][15:0] pcnt;
    ars_obj_e obj;
    ars_func_e func;
    logic [31:0] rdata;
  } ars_state_s;

endpackage

// ---- sim/ars_autoreclose_tb.sv ----
// Self-checking bench for the autoreclose sequencer: register tasks and shot runs.
// Assumes the breaker model in ars_brk_model.sv and a tick of 4 clock cycles.
`timescale 1ns/1ps
module ars_autoreclose_tb;
  import ars_pkg::*;
  localparam int TC = 4;
  logic clk, rst_n, wr, rd, oc, req1, req2, blk, stuck;
  logic [7:0] addr;
  logic [31:0] wdat, rdat;
  logic open_o, close_o, b_open, b_closed;
  logic [1:0] ftrip, kind;
  logic [3:0] func, obj, tgt_f, dly;
  logic [2:0] shot;
  logic [5:0] mon;
  int miscompares, tests_run, n;
  assign mon = {func == tgt_f, ftrip[1], b_closed, b_open, close_o, open_o};

  ars_autoreclose #(.TICK_CYCLES(TC)) i_dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdat),
    .WR_STB_I(wr), .RD_STB_I(rd), .RD_DATA_O(rdat), .OVERCURRENT_I(oc),
    .RECLOSE_REQUEST_ONE_I(req1), .RECLOSE_REQUEST_TWO_I(req2),
    .BRK_OPEN_I(b_open), .BRK_CLOSED_I(b_closed), .CLOSE_BLOCK_INPUT_I(blk),
    .OPEN_BREAKER_OUTPUT_O(open_o), .CLOSE_BREAKER_OUTPUT_O(close_o),
    .FINAL_TRIP_EVENT_O(ftrip), .FUNC_STATE_O(func), .BREAKER_OBJECT_STATE_O(obj),
    .SHOT_O(shot), .ACTIVE_TIMER_KIND_O(kind));

  ars_brk_model i_brk (.clk_i(clk), .rst_n_i(rst_n), .open_cmd_i(open_o),
    .close_cmd_i(close_o), .stuck_i(stuck), .dly_i(dly), .brk_open_o(b_open),
    .brk_closed_o(b_closed));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    chk({31'h0, (v >= lo && v <= hi)}, 32'h0000_0001);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask

  // Bounded wait for a monitor bit; a timeout ends the run
  task automatic wt(input int b, input logic lvl, input int lim, output int cyc);
    cyc = 0;
    #1;
    while (mon[b] !== lvl) begin
      @(posedge clk);
      #1;
      cyc++;
      if (cyc > lim) begin
        miscompares++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, mon[b], lvl);
        complete_run();
      end
    end
  endtask

  initial begin
    rst_n = 1'b0;
    {wr, rd, oc, req1, req2, blk, stuck} = 7'h00;
    addr = 8'h00;
    wdat = 32'h0000_0000;
    dly = 4'h2;
    tgt_f = FS_READY;
    miscompares = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    #1;
    chk(shot, 3'h1);
    chk(func, FS_INIT);
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(A_CTRL, 32'h0000_000b);
    rd_chk(A_RECLAIM, {16'h0000, RECLAIM_RST});
    rd_chk(A_DEAD + 8'h10, {16'h0000, DEAD_RST});
    rd_chk(A_START + 8'h10, {16'h0000, START_RST});
    rd_chk(A_DISCR + 8'h04, {16'h0000, DISCR_RST});
    rd_chk(A_BRK_TO, {16'h0000, BRK_TO_RST});
    rd_chk(8'hfc, 32'h0000_0000);
    wr_reg(A_RECLAIM, 32'h0000_0003);
    for (int i = 0; i < 5; i++) begin
      wr_reg(A_DEAD + 8'(4 * i), 32'(i + 2));
    end
    rd_chk(A_DEAD + 8'h04, 32'h0000_0003);
    $display("test registers done");

    // Two shots, fault cleared in the second
    wt(5, 1'b1, 20, n);
    @(posedge clk);
    oc <= 1'b1;
    req1 <= 1'b1;
    wt(0, 1'b1, 40, n);
    chk(kind, TK_START);
    chk(shot, 3'h1);
    chk(obj, OB_OPEN_REQ);
    wt(2, 1'b1, 20, n);
    wt(1, 1'b1, 60, n);
    rng(n, 2 * TC, 2 * TC + 3);
    chk(open_o, 1'b0);
    chk(kind, TK_DEAD);
    wt(3, 1'b1, 20, n);
    wt(1, 1'b0, 4, n);
    chk(kind, TK_DISCR);
    wt(0, 1'b1, 20, n);
    wt(2, 1'b1, 20, n);
    chk(shot, 3'h2);
    @(posedge clk);
    oc <= 1'b0;
    wt(1, 1'b1, 60, n);
    rng(n, 3 * TC - 1, 3 * TC + 3);
    tgt_f = FS_RECLAIM;
    wt(5, 1'b1, 40, n);
    chk(kind, TK_RECLAIM);
    tgt_f = FS_READY;
    wt(5, 1'b1, 3 * TC + 6, n);
    chk(shot, 3'h1);
    chk(obj, OB_CLOSE);
    @(posedge clk);
    req1 <= 1'b0;
    rd_chk(A_TOTAL, 32'h0000_0001);
    rd_chk(A_FAIL, 32'h0000_0001);
    rd_chk(A_CNT_ONE, 32'h0000_0001);
    rd_chk(A_CNT_ONE + 8'h04, 32'h0000_0001);
    rd_chk(A_CNT_TWO, 32'h0000_0000);
    wr_reg(A_CTRL, 32'h0000_0001);
    rd_chk(A_CTRL, 32'h0000_000b);
    $display("test two shots done");

    // One shot on request two, close held off, then final trip
    wr_reg(A_CTRL, 32'h0000_0003);
    @(posedge clk);
    blk <= 1'b1;
    oc <= 1'b1;
    req2 <= 1'b1;
    wt(2, 1'b1, 60, n);
    repeat (3 * TC + 4) @(posedge clk);
    #1;
    chk(close_o, 1'b0);
    @(posedge clk);
    blk <= 1'b0;
    wt(1, 1'b1, 3, n);
    wt(4, 1'b1, 40, n);
    chk(ftrip, 2'h2);
    wt(4, 1'b0, FTRIP_HOLD * TC + 8, n);
    rng(n, FTRIP_HOLD * TC - 4, FTRIP_HOLD * TC + 4);
    chk(ftrip, 2'h0);
    @(posedge clk);
    oc <= 1'b0;
    req2 <= 1'b0;
    rd_chk(A_FAIL, 32'h0000_0002);
    rd_chk(A_CNT_TWO, 32'h0000_0001);
    $display("test final trip done");

    // Second reset, then a breaker that never moves
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(A_TOTAL, 32'h0000_0000);
    tgt_f = FS_READY;
    wt(5, 1'b1, 20, n);
    @(posedge clk);
    stuck <= 1'b1;
    oc <= 1'b1;
    req1 <= 1'b1;
    wt(0, 1'b1, 40, n);
    tgt_f = FS_BRK_FAIL;
    wt(5, 1'b1, BRK_TO_RST * TC + 10, n);
    rng(n, BRK_TO_RST * TC - 4, BRK_TO_RST * TC + 8);
    rd_chk(A_STATUS, {18'h0_0000, TK_START, 1'b0, 3'h1, OB_FAIL, FS_BRK_FAIL});
    wr_reg(A_CTRL, 32'h0000_000a);
    tgt_f = FS_INHIBIT;
    wt(5, 1'b1, 6, n);
    $display("test breaker fail done");
    complete_run();
  end
endmodule

// ---- sim/ars_brk_model.sv ----
// Breaker model: open and close coils with position feedback.
// Assumes coil commands are held until the matching feedback shows.
`timescale 1ns/1ps
module ars_brk_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic open_cmd_i,
  input wire logic close_cmd_i,
  input wire logic stuck_i,
  input wire logic [3:0] dly_i,
  output logic brk_open_o,
  output logic brk_closed_o
);
  logic [3:0] cnt_q;
  logic pos_open_q;
  logic moving_q;
  logic go;
  assign go = !stuck_i && ((open_cmd_i && !pos_open_q) || (close_cmd_i && pos_open_q));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      pos_open_q <= 1'b0;
      moving_q <= 1'b0;
    end else if (go) begin
      // Contacts in travel show neither position
      moving_q <= 1'b1;
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= dly_i) begin
        pos_open_q <= ~pos_open_q;
        moving_q <= 1'b0;
        cnt_q <= 4'h0;
      end
    end
  end
  assign brk_open_o = pos_open_q && !moving_q;
  assign brk_closed_o = !pos_open_q && !moving_q;
endmodule
